/* charger_fault_event_flags.sv */
// charger event flags: low status bits, first read-clear interrupt register
`default_nettype none

module charger_fault_event_flags #(
	parameter logic [31:0] WDT_CYCLES = charger_event_pkg::WDT_CYCLES,
	parameter int          SYNC_W     = 13
) (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_b,
	// register port from the serial management engine
	input  wire logic [7:0] reg_addr,
	input  wire logic       reg_rd,
	input  wire logic       reg_wr,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	// analog comparator pins, asynchronous
	input  wire logic       primary_input,
	input  wire logic       secondary_input,
	input  wire logic       input_validation_fail,
	input  wire logic       batt_above_low_pin,
	input  wire logic       batt_absent_pin,
	input  wire logic [7:0] batt_below_min_pin,
	// charge controller state, same clock
	input  wire logic       charge_mode,
	input  wire logic       charging,
	input  wire logic       precharge_phase,
	input  wire logic       below_term_current,
	input  wire logic       termination_enable,
	input  wire logic [2:0] min_batt_threshold_sel,
	input  wire logic [3:0] batt_temp_zone,
	input  wire logic       safety_timer_expired,
	input  wire logic       watchdog_kick,
	// status and control outputs
	output logic            watchdog_enable_ctl,
	output logic            regs_to_default,
	output logic            batt_absent_status,
	output logic      [2:0] status_second,
	output logic      [7:0] int_events_zero
);

	// ------------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------------
	logic [SYNC_W-1:0] pins;
	logic [SYNC_W-1:0] s1_ff;
	logic [SYNC_W-1:0] s2_ff;
	logic [SYNC_W-1:0] s3_ff;
	logic [SYNC_W-1:0] filt_ff;
	logic [SYNC_W-1:0] prev_ff;

	assign pins = {batt_below_min_pin, batt_absent_pin, batt_above_low_pin,
		input_validation_fail, secondary_input, primary_input};

	// three stages; s1 feeds only s2 so metastability never fans out
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s1_ff <= '0;
			s2_ff <= '0;
			s3_ff <= '0;
		end else begin
			s1_ff <= pins;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	// a bit only moves once stages two and three agree
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			filt_ff <= '0;
			prev_ff <= '0;
		end else begin
			filt_ff <= (s2_ff & s3_ff) | (filt_ff & (s2_ff | s3_ff));
			prev_ff <= filt_ff;
		end
	end

	// ------------------------------------------------------------------
	// event decode
	// ------------------------------------------------------------------
	logic prim_now;
	logic prim_was;
	logic sec_now;
	logic sec_was;
	logic plug_in;
	logic plug_out;
	logic reinsert;
	logic low_above;
	logic low_cross;
	logic weak_now;
	logic charging_q_ff;
	logic precharge_q_ff;
	logic term_q_ff;

	assign prim_now  = filt_ff[0];
	assign prim_was  = prev_ff[0];
	assign sec_now   = filt_ff[1];
	assign sec_was   = prev_ff[1];
	assign plug_in   = (prim_now | sec_now) & ~(prim_was | sec_was);
	assign plug_out  = ~(prim_now | sec_now) & (prim_was | sec_was);
	assign reinsert  = (prim_now & ~prim_was) | (sec_now & ~sec_was);
	assign low_above = filt_ff[3];
	assign low_cross = filt_ff[3] ^ prev_ff[3];
	assign weak_now  = filt_ff[5 + 32'(min_batt_threshold_sel)];

	// previous values of same-clock controller levels for edge detection
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			charging_q_ff  <= 1'b0;
			precharge_q_ff <= 1'b0;
			term_q_ff      <= 1'b0;
		end else begin
			charging_q_ff  <= charging;
			precharge_q_ff <= precharge_phase;
			term_q_ff      <= below_term_current;
		end
	end

	logic [7:0] int_set;
	logic [7:0] int_clr;
	logic       int_read;

	// one set term per interrupt bit
	always_comb begin
		int_set = 8'h00;
		int_set[charger_event_pkg::INT_VALIDATION_FAIL] =
			filt_ff[2] & ~prev_ff[2];
		int_set[charger_event_pkg::INT_SECONDARY_INPUT] =
			(sec_now ^ sec_was) | (~prim_now & prim_was & sec_now);
		int_set[charger_event_pkg::INT_PRIMARY_INPUT] =
			prim_now ^ prim_was;
		int_set[charger_event_pkg::INT_BATT_LOW_CROSS] =
			(low_cross & charging) | (charging & ~charging_q_ff & low_above)
			| (plug_out & low_above);
		int_set[charger_event_pkg::INT_CHARGE_DONE] =
			termination_enable & charging & below_term_current
			& ~term_q_ff;
		int_set[charger_event_pkg::INT_PHASE_CHANGE] =
			charging & charging_q_ff
			& (precharge_phase ^ precharge_q_ff);
		int_set[charger_event_pkg::INT_WEAK_BATTERY] =
			plug_in & weak_now;
		int_set[charger_event_pkg::INT_BATT_PRESENCE] =
			filt_ff[4] ^ prev_ff[4];
	end

	// a read of the interrupt register clears every bit not set right now
	assign int_read = reg_rd
		& (reg_addr == charger_event_pkg::INT_EVENTS_ZERO_ADDR);
	assign int_clr  = {8{int_read}};

	sticky_flags #(
		.W   (8),
		.RST (charger_event_pkg::INT_EVENTS_ZERO_RST)
	) u_int_flags (
		.clk   (clk),
		.rst_b (rst_b),
		.set   (int_set),
		.clr   (int_clr),
		.q     (int_events_zero)
	);

	// ------------------------------------------------------------------
	// watchdog
	// ------------------------------------------------------------------
	logic [31:0] wdt_cnt_ff;
	logic        wdt_expire;
	logic        watchdog_enable_ctl_write;

	assign watchdog_enable_ctl_write = reg_wr & (reg_addr == charger_event_pkg::WDT_CTL_ADDR);
	assign wdt_expire = watchdog_enable_ctl & charge_mode
		& (wdt_cnt_ff == WDT_CYCLES - 32'd1);

	// counts only while enabled in charge mode; a kick restarts it
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wdt_cnt_ff <= 32'h0;
		end else if (!watchdog_enable_ctl || !charge_mode || watchdog_kick
			|| wdt_expire) begin
			wdt_cnt_ff <= 32'h0;
		end else begin
			wdt_cnt_ff <= wdt_cnt_ff + 32'd1;
		end
	end

	// expiry drops the enable; a host write sets or clears it
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			watchdog_enable_ctl <= charger_event_pkg::WDT_ENABLE_RST;
		end else if (wdt_expire) begin
			watchdog_enable_ctl <= 1'b0;
		end else if (watchdog_enable_ctl_write) begin
			watchdog_enable_ctl <= reg_wdata[charger_event_pkg::WDT_ENABLE_BIT];
		end
	end

	// one-cycle request to the rest of the register file to reload defaults
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			regs_to_default <= 1'b0;
		end else begin
			regs_to_default <= wdt_expire;
		end
	end

	// ------------------------------------------------------------------
	// status bits
	// ------------------------------------------------------------------
	logic [2:0] st_set;
	logic [2:0] st_clr;

	// temperature bit follows the zone, the two timeouts are sticky
	always_comb begin
		st_set = 3'h0;
		st_clr = 3'h0;
		st_set[charger_event_pkg::ST_BATT_TEMP_UNSAFE] =
			(batt_temp_zone == charger_event_pkg::TEMP_ZONE_COLD)
			| (batt_temp_zone == charger_event_pkg::TEMP_ZONE_HOT);
		st_clr[charger_event_pkg::ST_BATT_TEMP_UNSAFE] = 1'b1;
		st_set[charger_event_pkg::ST_WATCHDOG_TIMEOUT] = wdt_expire;
		st_clr[charger_event_pkg::ST_WATCHDOG_TIMEOUT] = reinsert
			| (watchdog_enable_ctl_write
			& reg_wdata[charger_event_pkg::WDT_ENABLE_BIT]);
		st_set[charger_event_pkg::ST_SAFETY_TIMER] = safety_timer_expired;
		st_clr[charger_event_pkg::ST_SAFETY_TIMER] = reinsert;
	end

	sticky_flags #(
		.W   (3),
		.RST (charger_event_pkg::STATUS_SECOND_RST)
	) u_status_flags (
		.clk   (clk),
		.rst_b (rst_b),
		.set   (st_set),
		.clr   (st_clr),
		.q     (status_second)
	);

	// battery absent level mirrors the filtered pin
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			batt_absent_status <= 1'b0;
		end else begin
			batt_absent_status <= filt_ff[4];
		end
	end

	// ------------------------------------------------------------------
	// register read data
	// ------------------------------------------------------------------
	// data shows one cycle after the read strobe; unmapped reads give zero
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			unique case (reg_addr)
				charger_event_pkg::STATUS_SECOND_ADDR:
					reg_rdata <= {5'h00, status_second};
				charger_event_pkg::INT_EVENTS_ZERO_ADDR:
					reg_rdata <= int_events_zero;
				charger_event_pkg::WDT_CTL_ADDR:
					reg_rdata <= {1'b0, watchdog_enable_ctl, 6'h00};
				default:
					reg_rdata <= 8'h00;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	read_clear_a: assert property (int_read && int_set == 8'h00
		|=> int_events_zero == 8'h00)
		else $error("interrupt register not cleared by read");
	set_wins_a: assert property (int_read && int_set != 8'h00
		|=> int_events_zero == $past(int_set))
		else $error("event lost on read-clear");
	read_data_a: assert property (int_read
		|=> reg_rdata == $past(int_events_zero))
		else $error("read data does not match interrupt register");
	temp_unsafe_a: assert property (batt_temp_zone == 4'hF
		|=> status_second[2])
		else $error("temperature unsafe bit not set");
	wdt_flag_a: assert property (wdt_expire
		|=> status_second[1] && !watchdog_enable_ctl && regs_to_default)
		else $error("watchdog expiry effects missing");
	wdt_clear_a: assert property (watchdog_enable_ctl_write && reg_wdata[6] && !wdt_expire
		|=> !status_second[1])
		else $error("watchdog flag not cleared by enable write");
	safety_flag_a: assert property (safety_timer_expired
		|=> status_second[0] ##1 (status_second[0] || $past(reinsert)))
		else $error("safety timer flag not held");
	prim_event_a: assert property ($changed(prim_now)
		|=> int_events_zero[5])
		else $error("primary input event missing");
	presence_a: assert property ($changed(filt_ff[4])
		|=> int_events_zero[0] ##1 batt_absent_status == filt_ff[4])
		else $error("battery presence event missing");
	phase_a: assert property (charging && $stable(charging)
		&& $changed(precharge_phase) |=> int_events_zero[2])
		else $error("charge phase change event missing");

	plug_in_c: cover property (plug_in ##[1:20] int_read);
	expire_c: cover property (wdt_expire ##[1:50] watchdog_enable_ctl_write);
	race_c: cover property (int_read && int_set != 8'h00);

endmodule : charger_fault_event_flags

`default_nettype wire

/* charger_event_pkg.sv */
// constants shared by the charger event-reporting logic
`default_nettype none

package charger_event_pkg;

	// ------------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------------
	localparam logic [7:0] STATUS_SECOND_ADDR   = 8'h02;
	localparam logic [7:0] INT_EVENTS_ZERO_ADDR = 8'h04;
	localparam logic [7:0] WDT_CTL_ADDR         = 8'h19;

	// ------------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------------
	localparam logic [7:0] INT_EVENTS_ZERO_RST = 8'h00;
	localparam logic [2:0] STATUS_SECOND_RST   = 3'h0;
	localparam logic       WDT_ENABLE_RST      = 1'b0;

	// ------------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------------
	localparam int ST_BATT_TEMP_UNSAFE  = 2;
	localparam int ST_WATCHDOG_TIMEOUT  = 1;
	localparam int ST_SAFETY_TIMER      = 0;
	localparam int WDT_ENABLE_BIT       = 6;
	localparam int INT_VALIDATION_FAIL  = 7;
	localparam int INT_SECONDARY_INPUT  = 6;
	localparam int INT_PRIMARY_INPUT    = 5;
	localparam int INT_BATT_LOW_CROSS   = 4;
	localparam int INT_CHARGE_DONE      = 3;
	localparam int INT_PHASE_CHANGE     = 2;
	localparam int INT_WEAK_BATTERY     = 1;
	localparam int INT_BATT_PRESENCE    = 0;

	// temperature zone codes that mean charging has stopped
	localparam logic [3:0] TEMP_ZONE_COLD = 4'h0;
	localparam logic [3:0] TEMP_ZONE_HOT  = 4'hF;

	// ------------------------------------------------------------------
	// timing
	// ------------------------------------------------------------------
	localparam longint CLK_HZ        = 64'd20_000_000;
	localparam longint WDT_TIME_S    = 64'd100;
	localparam logic [31:0] WDT_CYCLES = 32'(WDT_TIME_S * CLK_HZ);

endpackage : charger_event_pkg

`default_nettype wire

/* sticky_flags.sv */
// vector of sticky flag bits where a set beats a clear in the same cycle
`default_nettype none

module sticky_flags #(
	parameter int           W   = 8,
	parameter logic [W-1:0] RST = '0
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst_b,
	// per-bit set and clear strobes
	input  wire logic [W-1:0] set,
	input  wire logic [W-1:0] clr,
	// flag state
	output logic      [W-1:0] q
);

	// set wins so an event landing on a read-clear is never lost
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			q <= RST;
		end else begin
			q <= set | (q & ~clr);
		end
	end

endmodule : sticky_flags

`default_nettype wire

/* host_port_model.sv */
// host-side model that drives the register port of the event flags
`default_nettype none

module host_port_model (
	// clock
	input  wire logic       clk,
	// register port
	input  wire logic [7:0] reg_rdata,
	output logic      [7:0] reg_addr,
	output logic            reg_rd,
	output logic            reg_wr,
	output logic      [7:0] reg_wdata
);
	timeunit 1ns;
	timeprecision 1ns;

	// idle port at time zero
	initial begin
		reg_addr  = 8'h00;
		reg_rd    = 1'b0;
		reg_wr    = 1'b0;
		reg_wdata = 8'h00;
	end

	// ------------------------------------------------------------------
	// access tasks, entered one step after a rising edge
	// ------------------------------------------------------------------
	// a released address is inverted so a stale value never looks valid
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		reg_addr = a;
		reg_rd   = 1'b1;
		@(posedge clk);
		#1;
		reg_rd   = 1'b0;
		d        = reg_rdata;
		reg_addr = ~a;
		// idle edge so a following call never re-raises the strobe at once
		@(posedge clk);
		#1;
	endtask : rd

	// one-cycle write strobe, data inverted once released
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		reg_addr  = a;
		reg_wdata = v;
		reg_wr    = 1'b1;
		@(posedge clk);
		#1;
		reg_wr    = 1'b0;
		reg_addr  = ~a;
		reg_wdata = ~v;
		// idle edge between back-to-back accesses
		@(posedge clk);
		#1;
	endtask : wr

endmodule : host_port_model

`default_nettype wire

/* charger_fault_event_flags_tb_top.sv */
// self-checking testbench for the charger event flags
`default_nettype none

module charger_fault_event_flags_tb_top;
	timeunit 1ns;
	timeprecision 1ns;

	// watchdog count shortened so expiry comes quickly
	localparam logic [31:0] WDT_N = 32'd20;

	logic       clk = 1'b0;
	logic       rst_b, reg_rd, reg_wr, primary_input, secondary_input;
	logic       input_validation_fail, batt_above_low_pin, batt_absent_pin;
	logic       charge_mode, charging, precharge_phase, below_term_current;
	logic       termination_enable, safety_timer_expired, watchdog_kick;
	logic       watchdog_enable_ctl, regs_to_default, batt_absent_status;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, batt_below_min_pin;
	logic [7:0] int_events_zero, d;
	logic [3:0] batt_temp_zone;
	logic [2:0] min_batt_threshold_sel, status_second;
	int         n_mismatch, cmp_count;

	always #25 clk = ~clk;

	charger_fault_event_flags #(.WDT_CYCLES(WDT_N)) DUT (
		.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_rd(reg_rd),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.primary_input(primary_input), .secondary_input(secondary_input),
		.input_validation_fail(input_validation_fail),
		.batt_above_low_pin(batt_above_low_pin),
		.batt_absent_pin(batt_absent_pin),
		.batt_below_min_pin(batt_below_min_pin),
		.charge_mode(charge_mode), .charging(charging),
		.precharge_phase(precharge_phase),
		.below_term_current(below_term_current),
		.termination_enable(termination_enable),
		.min_batt_threshold_sel(min_batt_threshold_sel),
		.batt_temp_zone(batt_temp_zone),
		.safety_timer_expired(safety_timer_expired),
		.watchdog_kick(watchdog_kick),
		.watchdog_enable_ctl(watchdog_enable_ctl),
		.regs_to_default(regs_to_default),
		.batt_absent_status(batt_absent_status),
		.status_second(status_second), .int_events_zero(int_events_zero)
	);

	host_port_model host (
		.clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
		.reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata)
	);

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	task automatic chk(input string what, input logic [7:0] seen,
		input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	// keeps every drive one step after the rising edge
	task automatic tick(input int n);
		repeat (n) begin
			@(posedge clk);
			#1;
		end
	endtask : tick

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp,
		input string what);
		host.rd(a, d);
		chk(what, d, exp);
	endtask : rd_chk

	// pins need about five cycles; a second read proves the clear
	task automatic ev(input logic [7:0] exp, input string what);
		tick(8);
		chk(what, int_events_zero, exp);
		rd_chk(8'h04, exp, what);
		rd_chk(8'h04, 8'h00, "int_cleared");
		$display("test %s done", what);
	endtask : ev

	// bounded wait for the expiry pulse; a hang ends the run
	task automatic wdt_expire;
		charge_mode = 1'b1;
		for (int i = 0; i < 100 && regs_to_default !== 1'b1; i++)
			tick(1);
		charge_mode = 1'b0;
		if (regs_to_default !== 1'b1) begin
			n_mismatch++;
			$display("Error regs_to_default expected 1 seen 0");
			give_verdict();
		end
	endtask : wdt_expire

	task automatic give_verdict;
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : give_verdict

	// ------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------
	initial begin
		n_mismatch = 0;
		cmp_count = 0;
		rst_b = 1'b0;
		{primary_input, secondary_input, input_validation_fail} = 3'h0;
		{batt_above_low_pin, batt_absent_pin, charge_mode} = 3'h0;
		{charging, precharge_phase, below_term_current} = 3'h0;
		{termination_enable, safety_timer_expired, watchdog_kick} = 3'h0;
		batt_below_min_pin = 8'h08;
		min_batt_threshold_sel = 3'h3;
		batt_temp_zone = 4'h5;
		tick(12);
		rst_b = 1'b1;
		tick(8);
		rd_chk(8'h04, 8'h00, "int_reset");
		rd_chk(8'h02, 8'h00, "status_reset");
		rd_chk(8'h33, 8'h00, "unmapped");
		$display("test reset done");
		// pin events
		primary_input = 1'b1;
		ev(8'h22, "primary_in");
		batt_below_min_pin = 8'h00;
		secondary_input = 1'b1;
		ev(8'h40, "secondary_in");
		batt_above_low_pin = 1'b1;
		primary_input = 1'b0;
		ev(8'h60, "primary_out");
		input_validation_fail = 1'b1;
		ev(8'h80, "valid_fail");
		batt_absent_pin = 1'b1;
		ev(8'h01, "batt_gone");
		chk("absent", {7'h00, batt_absent_status}, 8'h01);
		// same-clock events
		charging = 1'b1;
		precharge_phase = 1'b1;
		ev(8'h10, "charge_start");
		precharge_phase = 1'b0;
		ev(8'h04, "phase_fast");
		termination_enable = 1'b1;
		below_term_current = 1'b1;
		ev(8'h08, "charge_end");
		// event lands on the same edge as the read-clear
		precharge_phase = 1'b1;
		rd_chk(8'h04, 8'h00, "clash_read");
		rd_chk(8'h04, 8'h04, "clash_kept");
		$display("test clash done");
		// status bits
		batt_temp_zone = 4'hF;
		tick(2);
		chk("temp_hot", {5'h00, status_second}, 8'h04);
		batt_temp_zone = 4'h0;
		tick(2);
		chk("temp_cold", {5'h00, status_second}, 8'h04);
		batt_temp_zone = 4'h7;
		tick(2);
		chk("temp_ok", {5'h00, status_second}, 8'h00);
		safety_timer_expired = 1'b1;
		tick(1);
		safety_timer_expired = 1'b0;
		tick(1);
		rd_chk(8'h02, 8'h01, "safety");
		host.wr(8'h19, 8'h40);
		rd_chk(8'h19, 8'h40, "watchdog_enable_ctl_set");
		wdt_expire();
		chk("defaults_req", {7'h00, regs_to_default}, 8'h01);
		chk("wdt_status", {5'h00, status_second}, 8'h03);
		chk("watchdog_enable_ctl_clr", {7'h00, watchdog_enable_ctl}, 8'h00);
		host.wr(8'h19, 8'h40);
		tick(1);
		chk("wdt_clr_wr", {5'h00, status_second}, 8'h01);
		wdt_expire();
		chk("wdt_again", {5'h00, status_second}, 8'h03);
		secondary_input = 1'b0;
		tick(8);
		chk("plug_out", int_events_zero, 8'h50);
		secondary_input = 1'b1;
		tick(8);
		chk("reinsert", {5'h00, status_second}, 8'h00);
		$display("test status done");
		give_verdict();
	end

endmodule : charger_fault_event_flags_tb_top

`default_nettype wire
